// [inc/icr_pkg.sv]
// Package: register map, field positions and carriers of the interrupt control slice
package icr_pkg;
  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // ------------------------------------------------------------
  // Register offsets (word index)
  // ------------------------------------------------------------
  localparam logic [2:0] OFF_CPU_STATUS = 3'h0;
  localparam logic [2:0] OFF_CORE_CTRL  = 3'h1;
  localparam logic [2:0] OFF_IRQ_CTRL1  = 3'h2;
  localparam logic [2:0] OFF_IRQ_CTRL2  = 3'h3;
  localparam logic [2:0] OFF_IRQ_FLAG0  = 3'h4;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int PRI_LOW_LSB = 5;
  localparam int PRI_LOW_W   = 3;
  localparam int PRI_EXT_BIT = 3;
  localparam int NEST_DIS    = 15;
  localparam int TRAP_LSB    = 1;
  localparam int TRAP_W      = 6;
  localparam int ALT_VEC     = 15;
  localparam int TIMED_DISABLE_ACTIVE_BIT    = 14;
  localparam int EP_W        = 5;
  localparam int FLAG_W      = 15;
  localparam int FLAG_EXT0   = 0;
  // Trap vector index, counted from TRAP_LSB
  localparam int TR_OSC  = 0;
  localparam int TR_STK  = 1;
  localparam int TR_ADDR = 2;
  localparam int TR_MATH = 3;
  localparam int TR_DMA  = 4;
  localparam int TR_DIV0 = 5;

  // ------------------------------------------------------------
  // Reset values and limits
  // ------------------------------------------------------------
  localparam logic [2:0]  RST_PRI_LOW = 3'h0;
  localparam logic [5:0]  RST_TRAP    = 6'h00;
  localparam logic [4:0]  RST_EP      = 5'h00;
  localparam logic [14:0] RST_FLAG    = 15'h0000;
  localparam logic [15:0] RD_ZERO     = 16'h0000;
  localparam logic [3:0]  PRI_LOW_MAX = 4'h7;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic div0;
    logic dma_err;
    logic arith;
    logic addr;
    logic stack;
    logic osc_fail;
  } icr_trap_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] level;
  } icr_pri_load_t;
endpackage

// [hw/icr_regs.sv]
// Interrupt control and status register slice with core priority level
// Functional notes
// - Priority-extension bit, hardware set, software clear
// - Level is extension bit above low bits
// - Nesting disable bit, resets to zero
// - Divide-zero flag tracks latest arithmetic trap
// - DMA error trap sets its flag
// - Arithmetic trap sets its flag
// - Address error trap sets its flag
// - Stack error trap sets its flag
// - Oscillator failure trap sets its flag
// - Unused control-one bits read zero
// - Vector select bit picks alternate table
// - Timed-disable status bit is read only
// - Polarity bits pick falling or rising edge
// - Flags show requests; ADC flag bit 13
// - DMA one flag bit 14, bit 15 zero
// - UART, SPI and timer three flag positions
// - Low flag byte positions, external zero last
// - Sources set flags, software clears them
// - Low priority bits locked while nesting disabled
// - Extension bit blocks all user interrupts
`timescale 1ns/1ns
`default_nettype none

module icr_regs (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  clk_en_i,
  input  wire logic [2:0]            reg_addr_i,
  input  wire logic [15:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire icr_pkg::icr_trap_t    trap_evt_i,
  input  wire icr_pkg::icr_pri_load_t pri_load_i,
  input  wire logic                  timed_disable_active_active_i,
  input  wire logic [14:1]           periph_set_i,
  input  wire logic                  ext_irq0_i,
  output logic [15:0]                reg_rdata_o,
  output logic [3:0]                 cpu_priority_o,
  output logic                       user_irq_block_o,
  output logic                       nesting_disable_o,
  output logic                       alt_vector_select_o,
  output logic [4:0]                 ext_edge_polarity_o,
  output logic [5:0]                 trap_flags_o,
  output logic [14:0]                irq_flags_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [2:0]  pri_low_reg;
  logic [2:0]  pri_low_next;
  logic        pri_ext_reg;
  logic        pri_ext_next;
  logic        nest_dis_reg;
  logic        nest_dis_next;
  logic [5:0]  trap_reg;
  logic [5:0]  trap_next;
  logic        alt_vec_reg;
  logic        alt_vec_next;
  logic [4:0]  ep_reg;
  logic [4:0]  ep_next;
  logic [14:0] flag_reg;
  logic [14:0] flag_next;
  logic        ext_prev_reg;
  logic        ext_arm_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire logic wr_status = reg_wr_i && (reg_addr_i == icr_pkg::OFF_CPU_STATUS);
  wire logic wr_core   = reg_wr_i && (reg_addr_i == icr_pkg::OFF_CORE_CTRL);
  wire logic wr_ctrl1  = reg_wr_i && (reg_addr_i == icr_pkg::OFF_IRQ_CTRL1);
  wire logic wr_ctrl2  = reg_wr_i && (reg_addr_i == icr_pkg::OFF_IRQ_CTRL2);
  wire logic wr_flag0  = reg_wr_i && (reg_addr_i == icr_pkg::OFF_IRQ_FLAG0);
  wire logic [3:0] load_lvl = pri_load_i.level;
  wire logic       load_v   = pri_load_i.valid;

  // ------------------------------------------------------------
  // Priority level
  // ------------------------------------------------------------
  // low bits locked
  // Core loads win over software; locked writes are dropped silently
  wire logic sw_pri_ok = wr_status && !nest_dis_reg;
  assign pri_low_next = load_v ? load_lvl[2:0] :
                        sw_pri_ok ? reg_wdata_i[7:5] : pri_low_reg;

  // clear only bit
  // Only the core can raise it, so traps stay unmaskable
  wire logic ext_sw_clr = wr_core && !reg_wdata_i[icr_pkg::PRI_EXT_BIT];
  assign pri_ext_next = load_v ? load_lvl[3] :
                        ext_sw_clr ? 1'b0 : pri_ext_reg;

  // ------------------------------------------------------------
  // Control register one
  // ------------------------------------------------------------
  // nesting control
  assign nest_dis_next = wr_ctrl1 ? reg_wdata_i[icr_pkg::NEST_DIS] : nest_dis_reg;

  wire logic [5:0] trap_set = {trap_evt_i.div0 & trap_evt_i.arith,
                               trap_evt_i.dma_err,
                               trap_evt_i.arith,
                               trap_evt_i.addr,
                               trap_evt_i.stack,
                               trap_evt_i.osc_fail};

  wire logic [5:0] trap_sw = wr_ctrl1 ? reg_wdata_i[6:1] : trap_reg;

  // latest cause only
  // A plain arithmetic trap drops an older divide-by-zero mark
  wire logic [5:0] trap_keep = trap_evt_i.arith ? (trap_sw & 6'h1f) : trap_sw;
  assign trap_next = trap_keep | trap_set;

  // ------------------------------------------------------------
  // Control register two
  // ------------------------------------------------------------
  // vector table select
  assign alt_vec_next = wr_ctrl2 ? reg_wdata_i[icr_pkg::ALT_VEC] : alt_vec_reg;
  assign ep_next = wr_ctrl2 ? reg_wdata_i[4:0] : ep_reg;

  // ------------------------------------------------------------
  // External interrupt zero edge detect
  // ------------------------------------------------------------
  // Armed after one sample so a high pin at reset is no edge
  wire logic ext_rise = ext_irq0_i && !ext_prev_reg;
  wire logic ext_fall = !ext_irq0_i && ext_prev_reg;
  wire logic ext_edge = ext_arm_reg && (ep_reg[0] ? ext_fall : ext_rise);

  // ------------------------------------------------------------
  // Flag register zero
  // ------------------------------------------------------------
  // middle flag sources
  wire logic [14:0] flag_set = {periph_set_i, ext_edge};
  // set wins clear
  // A request in the clearing cycle survives the write
  assign flag_next = (wr_flag0 ? reg_wdata_i[14:0] : flag_reg) | flag_set;

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  // level concatenation
  wire logic [15:0] rd_status = {8'h00, pri_low_reg, 5'h00};
  wire logic [15:0] rd_core   = {12'h000, pri_ext_reg, 3'h0};
  wire logic [15:0] rd_ctrl1  = {nest_dis_reg, 8'h00, trap_reg, 1'b0};
  wire logic [15:0] rd_ctrl2  = {alt_vec_reg, timed_disable_active_active_i, 9'h000, ep_reg};
  wire logic [15:0] rd_flag0  = {1'b0, flag_reg};
  wire logic [15:0] rd_mux =
    (reg_addr_i == icr_pkg::OFF_CPU_STATUS) ? rd_status :
    (reg_addr_i == icr_pkg::OFF_CORE_CTRL)  ? rd_core   :
    (reg_addr_i == icr_pkg::OFF_IRQ_CTRL1)  ? rd_ctrl1  :
    (reg_addr_i == icr_pkg::OFF_IRQ_CTRL2)  ? rd_ctrl2  :
    (reg_addr_i == icr_pkg::OFF_IRQ_FLAG0)  ? rd_flag0  : icr_pkg::RD_ZERO;
  // Data valid only in the cycle after the strobe
  assign rdata_next = reg_rd_i ? rd_mux : icr_pkg::RD_ZERO;

  // ------------------------------------------------------------
  // Priority and control flops
  // ------------------------------------------------------------
  // Clock enable low freezes every flop
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pri_low_reg  <= icr_pkg::RST_PRI_LOW;
      pri_ext_reg  <= 1'b0;
      nest_dis_reg <= 1'b0;
      alt_vec_reg  <= 1'b0;
      ep_reg       <= icr_pkg::RST_EP;
    end else if (clk_en_i) begin
      pri_low_reg  <= pri_low_next;
      pri_ext_reg  <= pri_ext_next;
      nest_dis_reg <= nest_dis_next;
      alt_vec_reg  <= alt_vec_next;
      ep_reg       <= ep_next;
    end
  end

  // Status flag flops
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trap_reg <= icr_pkg::RST_TRAP;
      flag_reg <= icr_pkg::RST_FLAG;
    end else if (clk_en_i) begin
      trap_reg <= trap_next;
      flag_reg <= flag_next;
    end
  end

  // Edge history and read data
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_prev_reg <= 1'b0;
      ext_arm_reg  <= 1'b0;
      rdata_reg    <= icr_pkg::RD_ZERO;
    end else if (clk_en_i) begin
      ext_prev_reg <= ext_irq0_i;
      ext_arm_reg  <= 1'b1;
      rdata_reg    <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // four-bit level
  assign cpu_priority_o      = {pri_ext_reg, pri_low_reg};
  assign user_irq_block_o    = pri_ext_reg;
  assign nesting_disable_o   = nest_dis_reg;
  assign alt_vector_select_o = alt_vec_reg;
  assign ext_edge_polarity_o = ep_reg;
  assign trap_flags_o        = trap_reg;
  assign irq_flags_o         = flag_reg;
  assign reg_rdata_o         = rdata_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  ext_clear_only_a: assert property (
    clk_en_i && wr_core && !load_v && !pri_ext_reg |=> !pri_ext_reg)
    else $error("extension bit set by software");

  pri_load_a: assert property (
    clk_en_i && load_v |=> cpu_priority_o == $past(load_lvl))
    else $error("priority load not taken");

  nest_write_a: assert property (
    clk_en_i && wr_ctrl1 |=> nesting_disable_o == $past(reg_wdata_i[15]))
    else $error("nesting bit not written");

  div0_cause_a: assert property (
    clk_en_i && trap_evt_i.arith |=>
      trap_flags_o[icr_pkg::TR_DIV0] == $past(trap_evt_i.div0))
    else $error("divide flag wrong after trap");

  trap_set_a: assert property (
    clk_en_i ##0 (trap_set[4:0] != 5'h00) |=>
      (trap_flags_o[4:0] & $past(trap_set[4:0])) == $past(trap_set[4:0]))
    else $error("trap event lost");

  ctrl1_zero_a: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == icr_pkg::OFF_IRQ_CTRL1 |=>
      reg_rdata_o[14:7] == 8'h00 && !reg_rdata_o[0])
    else $error("unused control bits not zero");

  alt_write_a: assert property (
    clk_en_i && wr_ctrl2 |=> alt_vector_select_o == $past(reg_wdata_i[15]))
    else $error("vector select not written");

  timed_disable_active_read_a: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == icr_pkg::OFF_IRQ_CTRL2 |=>
      reg_rdata_o[14] == $past(timed_disable_active_active_i))
    else $error("timed disable status misread");

  ext_edge_a: assert property (
    clk_en_i && ext_arm_reg && ext_prev_reg && !ext_irq0_i && ep_reg[0] |=>
      irq_flags_o[icr_pkg::FLAG_EXT0])
    else $error("falling edge not flagged");

  flag15_zero_a: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == icr_pkg::OFF_IRQ_FLAG0 |=>
      !reg_rdata_o[15] && reg_rdata_o[14:0] == $past(flag_reg))
    else $error("flag readback wrong");

  flag_set_a: assert property (
    clk_en_i && periph_set_i[13] |=> irq_flags_o[13])
    else $error("peripheral request lost");

  pri_lock_a: assert property (
    clk_en_i && wr_status && nest_dis_reg && !load_v |=> $stable(pri_low_reg))
    else $error("locked priority bits changed");

  user_block_a: assert property (
    clk_en_i && load_v |=> user_irq_block_o == ($past(load_lvl) > icr_pkg::PRI_LOW_MAX))
    else $error("block does not track level");

  trap_clear_a: assert property (
    clk_en_i && wr_ctrl1 && !reg_wdata_i[3] && !trap_evt_i.addr |=>
      !trap_flags_o[icr_pkg::TR_ADDR])
    else $error("trap flag not cleared");

  // Arithmetic, address, stack and oscillator traps land on their own flags
  arith_set_a: assert property (
    clk_en_i && trap_evt_i.arith |=> trap_flags_o[icr_pkg::TR_MATH])
    else $error("arithmetic trap not flagged");

  addr_set_a: assert property (
    clk_en_i && trap_evt_i.addr |=> trap_flags_o[icr_pkg::TR_ADDR])
    else $error("address trap not flagged");

  stack_set_a: assert property (
    clk_en_i && trap_evt_i.stack |=> trap_flags_o[icr_pkg::TR_STK])
    else $error("stack trap not flagged");

  osc_set_a: assert property (
    clk_en_i && trap_evt_i.osc_fail |=> trap_flags_o[icr_pkg::TR_OSC])
    else $error("oscillator trap not flagged");

  // Traps clear only on a control write, or for divide-by-zero also on a plain arithmetic trap
  trap_hold_a: assert property (
    clk_en_i && !wr_ctrl1 && trap_flags_o[icr_pkg::TR_STK] |=>
      trap_flags_o[icr_pkg::TR_STK])
    else $error("trap flag dropped without write");

  // Flag positions for a few sources
  dma1_flag_a: assert property (
    clk_en_i && periph_set_i[14] |=> irq_flags_o[14])
    else $error("channel one flag lost");

  uart_flag_a: assert property (
    clk_en_i && periph_set_i[12] |=> irq_flags_o[12])
    else $error("transmit flag lost");

  low_flag_a: assert property (
    clk_en_i && periph_set_i[7] |=> irq_flags_o[7])
    else $error("timer two flag lost");

  flag_hold_a: assert property (
    clk_en_i && !wr_flag0 && irq_flags_o[3] |=> irq_flags_o[3])
    else $error("flag dropped without write");

  // Control bits move only on their own register write
  nest_hold_a: assert property (
    clk_en_i && !wr_ctrl1 |=> $stable(nesting_disable_o))
    else $error("nesting bit changed unasked");

  ep_write_a: assert property (
    clk_en_i && wr_ctrl2 |=> ext_edge_polarity_o == $past(reg_wdata_i[4:0]))
    else $error("polarity bits not written");

  // Readback of the priority level halves
  status_read_a: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == icr_pkg::OFF_CPU_STATUS |=>
      reg_rdata_o[7:5] == $past(cpu_priority_o[2:0]))
    else $error("low priority bits misread");

  core_read_a: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == icr_pkg::OFF_CORE_CTRL |=>
      reg_rdata_o[3] == $past(cpu_priority_o[3]))
    else $error("extension bit misread");

  // Enable low must hold every flop, so a stalled core keeps its state
  state_freeze_a: assert property (
    !clk_en_i |=> $stable(trap_flags_o) && $stable(irq_flags_o) && $stable(cpu_priority_o))
    else $error("state moved while enable low");

  // ------------------------------------------------------------
  // Scenario covers
  // ------------------------------------------------------------
  trap_cv: cover property (clk_en_i && trap_evt_i.div0 && trap_evt_i.arith);
  lock_cv: cover property (clk_en_i && wr_status && nest_dis_reg);
  race_cv: cover property (clk_en_i && wr_flag0 && |flag_set);
  edge_cv: cover property (clk_en_i && ext_edge);
  freeze_cv: cover property (!clk_en_i && |trap_set);

endmodule

`default_nettype wire

// [tb/icr_src_model.sv]
// Behavioural core and peripheral sources feeding the slice's event inputs
`timescale 1ns/1ns
`default_nettype none

module icr_src_model (
  input  wire logic                    sys_clk_i,
  output var  icr_pkg::icr_trap_t      trap_evt_o,
  output var  icr_pkg::icr_pri_load_t  pri_load_o,
  output logic                         timed_disable_active_active_o,
  output logic [14:1]                  periph_set_o,
  output logic                         ext_irq0_o
);
  // Idle levels from time zero
  initial begin
    trap_evt_o = '0;
    pri_load_o = '0;
    timed_disable_active_active_o = 1'b0;
    periph_set_o = '0;
    ext_irq0_o = 1'b0;
  end

  // sources raise requests
  // One-cycle request pulses, driven just after an edge
  task automatic pulse(input icr_pkg::icr_trap_t t, input logic [14:1] p);
    @(posedge sys_clk_i);
    trap_evt_o <= t;
    periph_set_o <= p;
    @(posedge sys_clk_i);
    trap_evt_o <= '0;
    periph_set_o <= '0;
    #1;
  endtask

  // Core vectoring loads a new level
  task automatic load(input logic [3:0] lvl);
    @(posedge sys_clk_i);
    pri_load_o <= '{valid: 1'b1, level: lvl};
    @(posedge sys_clk_i);
    pri_load_o <= '0;
    #1;
  endtask

  // Pin and timed-disable levels
  task automatic level(input logic pin, input logic timed_disable_active);
    @(posedge sys_clk_i);
    ext_irq0_o <= pin;
    timed_disable_active_active_o <= timed_disable_active;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
endmodule

`default_nettype wire

// [tb/icr_regs_test.sv]
// Self-checking bench for the interrupt control and status slice
`timescale 1ns/1ns
`default_nettype none

module icr_regs_test;
  logic                   sys_clk_i = 1'b0;
  logic                   rst_b_i = 1'b0;
  logic                   clk_en_i = 1'b1;
  logic [2:0]             reg_addr_i = 3'h0;
  logic [15:0]            reg_wdata_i = 16'h0000;
  logic                   reg_wr_i = 1'b0;
  logic                   reg_rd_i = 1'b0;
  icr_pkg::icr_trap_t     trap_evt_i;
  icr_pkg::icr_pri_load_t pri_load_i;
  logic                   timed_disable_active_active_i;
  logic [14:1]            periph_set_i;
  logic                   ext_irq0_i;
  logic [15:0]            reg_rdata_o;
  logic [3:0]             cpu_priority_o;
  logic                   user_irq_block_o;
  logic                   nesting_disable_o;
  logic                   alt_vector_select_o;
  logic [4:0]             ext_edge_polarity_o;
  logic [5:0]             trap_flags_o;
  logic [14:0]            irq_flags_o;
  int                     bad_count = 0;
  int                     cmp_count = 0;
  int                     cycles = 0;

  // ------------------------------------------------------------
  // Clock, timeout, instances
  // ------------------------------------------------------------
  always #5 sys_clk_i = ~sys_clk_i;

  // Whole run needs about 250 cycles; a hang ends the run
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      print_verdict();
    end
  end

  icr_regs DUT (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .trap_evt_i(trap_evt_i), .pri_load_i(pri_load_i),
    .timed_disable_active_active_i(timed_disable_active_active_i), .periph_set_i(periph_set_i), .ext_irq0_i(ext_irq0_i),
    .reg_rdata_o(reg_rdata_o), .cpu_priority_o(cpu_priority_o),
    .user_irq_block_o(user_irq_block_o), .nesting_disable_o(nesting_disable_o),
    .alt_vector_select_o(alt_vector_select_o), .ext_edge_polarity_o(ext_edge_polarity_o),
    .trap_flags_o(trap_flags_o), .irq_flags_o(irq_flags_o)
  );

  icr_src_model src (
    .sys_clk_i(sys_clk_i), .trap_evt_o(trap_evt_i), .pri_load_o(pri_load_i),
    .timed_disable_active_active_o(timed_disable_active_active_i), .periph_set_o(periph_set_i), .ext_irq0_o(ext_irq0_i)
  );

  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  // Write strobe for one cycle, outputs settle at the taking edge
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("read data", reg_rdata_o, exp);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 6; a++) rd_chk(3'(a), 16'h0000);
  endtask

  task automatic t_ctrl1();
    wr(icr_pkg::OFF_IRQ_CTRL1, 16'hffff);
    chk("nesting", {15'h0, nesting_disable_o}, 16'h0001);
    rd_chk(icr_pkg::OFF_IRQ_CTRL1, 16'h807e);
    wr(icr_pkg::OFF_IRQ_CTRL1, 16'h0000);
    rd_chk(icr_pkg::OFF_IRQ_CTRL1, 16'h0000);
  endtask

  task automatic t_traps();
    for (int i = 0; i < 5; i++) begin
      src.pulse(icr_pkg::icr_trap_t'(6'h01 << i), '0);
      chk("trap flags", {10'h0, trap_flags_o}, 16'h0001 << i);
      rd_chk(icr_pkg::OFF_IRQ_CTRL1, 16'h0002 << i);
      wr(icr_pkg::OFF_IRQ_CTRL1, 16'h0000);
    end
    src.pulse(6'h28, '0);
    repeat (3) @(posedge sys_clk_i);
    rd_chk(icr_pkg::OFF_IRQ_CTRL1, 16'h0050);
    // Arithmetic trap without divide cause drops the divide flag
    src.pulse(6'h08, '0);
    chk("trap flags", {10'h0, trap_flags_o}, 16'h0008);
    wr(icr_pkg::OFF_IRQ_CTRL1, 16'h0000);
    chk("trap flags", {10'h0, trap_flags_o}, 16'h0000);
  endtask

  task automatic t_ctrl2();
    wr(icr_pkg::OFF_IRQ_CTRL2, 16'hffff);
    chk("alt vector", {15'h0, alt_vector_select_o}, 16'h0001);
    chk("polarity", {11'h0, ext_edge_polarity_o}, 16'h001f);
    rd_chk(icr_pkg::OFF_IRQ_CTRL2, 16'h801f);
    src.level(1'b0, 1'b1);
    rd_chk(icr_pkg::OFF_IRQ_CTRL2, 16'hc01f);
    src.level(1'b0, 1'b0);
    wr(icr_pkg::OFF_IRQ_CTRL2, 16'h0000);
  endtask

  task automatic t_flags();
    for (int n = 1; n < 15; n++) begin
      src.pulse('0, 14'h0001 << (n - 1));
      chk("irq flags", {1'b0, irq_flags_o}, 16'h0001 << n);
      rd_chk(icr_pkg::OFF_IRQ_FLAG0, 16'h0001 << n);
      wr(icr_pkg::OFF_IRQ_FLAG0, 16'h0000);
    end
    wr(icr_pkg::OFF_IRQ_FLAG0, 16'hffff);
    rd_chk(icr_pkg::OFF_IRQ_FLAG0, 16'h7fff);
    wr(icr_pkg::OFF_IRQ_FLAG0, 16'h0000);
  endtask

  task automatic t_ext0();
    // rising edge counts only with polarity 0
    src.level(1'b1, 1'b0);
    chk("ext flag", {15'h0, irq_flags_o[0]}, 16'h0001);
    wr(icr_pkg::OFF_IRQ_FLAG0, 16'h0000);
    src.level(1'b0, 1'b0);
    chk("ext flag", {15'h0, irq_flags_o[0]}, 16'h0000);
    wr(icr_pkg::OFF_IRQ_CTRL2, 16'h0001);
    src.level(1'b1, 1'b0);
    chk("ext flag", {15'h0, irq_flags_o[0]}, 16'h0000);
    src.level(1'b0, 1'b0);
    rd_chk(icr_pkg::OFF_IRQ_FLAG0, 16'h0001);
    wr(icr_pkg::OFF_IRQ_FLAG0, 16'h0000);
    wr(icr_pkg::OFF_IRQ_CTRL2, 16'h0000);
  endtask

  task automatic t_priority();
    src.load(4'h9);
    chk("level", {12'h0, cpu_priority_o}, 16'h0009);
    chk("block", {15'h0, user_irq_block_o}, 16'h0001);
    rd_chk(icr_pkg::OFF_CORE_CTRL, 16'h0008);
    rd_chk(icr_pkg::OFF_CPU_STATUS, 16'h0020);
    wr(icr_pkg::OFF_CORE_CTRL, 16'h0000);
    chk("block", {15'h0, user_irq_block_o}, 16'h0000);
    wr(icr_pkg::OFF_CORE_CTRL, 16'h0008);
    rd_chk(icr_pkg::OFF_CORE_CTRL, 16'h0000);
    src.load(4'h7);
    chk("block", {15'h0, user_irq_block_o}, 16'h0000);
    // low bits locked while nesting disabled
    wr(icr_pkg::OFF_IRQ_CTRL1, 16'h8000);
    wr(icr_pkg::OFF_CPU_STATUS, 16'h0000);
    chk("level", {12'h0, cpu_priority_o}, 16'h0007);
    wr(icr_pkg::OFF_IRQ_CTRL1, 16'h0000);
    wr(icr_pkg::OFF_CPU_STATUS, 16'h00a0);
    chk("level", {12'h0, cpu_priority_o}, 16'h0005);
  endtask

  task automatic t_freeze();
    // Enable low: events and writes are ignored
    @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    src.pulse(6'h04, 14'h0001);
    wr(icr_pkg::OFF_IRQ_CTRL1, 16'h8000);
    chk("frozen traps", {10'h0, trap_flags_o}, 16'h0000);
    chk("frozen flags", {1'b0, irq_flags_o}, 16'h0000);
    chk("frozen nesting", {15'h0, nesting_disable_o}, 16'h0000);
    @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    wr(icr_pkg::OFF_IRQ_CTRL1, 16'h8000);
    src.pulse(6'h04, 14'h0001);
    chk("trap flags", {10'h0, trap_flags_o}, 16'h0004);
    // Reset in mid-run clears every register
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_ctrl1();
    t_traps();
    t_ctrl2();
    t_flags();
    t_ext0();
    t_priority();
    t_freeze();
    print_verdict();
  end
endmodule

`default_nettype wire
